//--- dv/hardware_return_stack_bench.sv
// hardware_return_stack_bench: apb and sequencer tests of the stack
`timescale 1ns/1ns
`default_nettype none
module hardware_return_stack_bench;
  import hrs_pkg::*;
  logic mclk = 1'b0;
  logic reset_n;
  logic ce;
  logic [ADDR_W-1:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic push_req;
  logic [PC_W-1:0] push_pc;
  logic pop_req;
  logic [PC_W-1:0] pop_pc;
  logic pop_valid;
  logic fault_reset;
  logic irq;
  logic last_err;
  logic [31:0] d;
  logic [PC_W-1:0] p;
  logic ok;
  int n_fail = 0;
  int n_tests = 0;
  int n_fr = 0;
  always #4 mclk = ~mclk;
  hrs_top dut_u (.mclk(mclk), .reset_n(reset_n), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .push_req(push_req), .push_pc(push_pc), .pop_req(pop_req),
    .pop_pc(pop_pc), .pop_valid(pop_valid), .fault_reset(fault_reset), .irq(irq));
  hrs_seq_model seq_u (.mclk(mclk), .push_req(push_req), .push_pc(push_pc),
    .pop_req(pop_req), .pop_pc(pop_pc), .pop_valid(pop_valid));
  always @(posedge mclk)
  begin
    if (fault_reset === 1'b1)
      n_fr++;
  end
  // ----
  // bus tasks
  // ----
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    // no wait count assumed: only the watchdog ends a stalled access
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    d = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic final_report;
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #40000;
    n_fail++;
    final_report();
  end
  // ----
  // tests
  // ----
  initial
  begin
    reset_n = 1'b0;
    ce = 1'b1;
    paddr = '0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = '0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    rd(OFS_PTR);
    chk("ptr_reset", d, 32'h1F);
    rd(OFS_CFG);
    chk("cfg_reset", d, 32'h1);
    rd(OFS_STAT);
    chk("stat_reset", d, 32'h0);
    rd(8'h40);
    chk("unmapped", {last_err, d[30:0]}, 32'h80000000);
    for (int i = 0; i < 3; i++)
      seq_u.call_op(15'h5A30 + 15'(i));
    rd(OFS_PTR);
    chk("ptr_push3", d, 32'h2);
    rd(OFS_TOP_ENTRY_LOW_BYTE);
    chk("tos_low", d, 32'h32);
    rd(OFS_TOP_ENTRY_HIGH_BYTE);
    chk("tos_high", d, 32'h5A);
    seq_u.ret_op(p, ok);
    chk("pop_last", {ok, p}, {1'b1, 15'h5A32});
    rd(OFS_PTR);
    chk("ptr_pop", d, 32'h1);
    // no push runs while software moves the pointer
    apb(1'b1, OFS_PTR, 32'h0);
    rd(OFS_TOP_ENTRY_LOW_BYTE);
    chk("tos_low_e0", d, 32'h30);
    apb(1'b1, OFS_TOP_ENTRY_LOW_BYTE, 32'hC3);
    apb(1'b1, OFS_TOP_ENTRY_HIGH_BYTE, 32'h15);
    seq_u.ret_op(p, ok);
    chk("pop_sw", {ok, p}, {1'b1, 15'h15C3});
    seq_u.ret_op(p, ok);
    rd(OFS_STAT);
    chk("unf_flag", d, 32'h2);
    chk("fault_pulses", n_fr, 1);
    rd(OFS_PTR);
    chk("ptr_fault", d, 32'h1F);
    @(negedge mclk);
    chk("irq_masked", irq, 1'b0);
    apb(1'b1, OFS_MASK, 32'h2);
    @(negedge mclk);
    chk("irq_on", irq, 1'b1);
    apb(1'b1, OFS_STAT, 32'h2);
    @(negedge mclk);
    chk("irq_off", irq, 1'b0);
    rd(OFS_STAT);
    chk("stat_w1c", d, 32'h0);
    apb(1'b1, OFS_CFG, 32'h0);
    apb(1'b1, OFS_MASK, 32'h3);
    for (int i = 0; i < 17; i++)
      seq_u.call_op(15'h0100 + 15'(i));
    rd(OFS_PTR);
    chk("ptr_wrap", d, 32'h10);
    chk("no_fault", n_fr, 1);
    rd(OFS_STAT);
    chk("ovf_flag", d, 32'h1);
    @(negedge mclk);
    chk("irq_ovf", irq, 1'b1);
    seq_u.ret_op(p, ok);
    chk("pop_17th", {ok, p}, {1'b1, 15'h0110});
    seq_u.ret_op(p, ok);
    chk("pop_16th", {ok, p}, {1'b1, 15'h010F});
    seq_u.call_ret_op(15'h2222, p, ok);
    chk("push_pop", {ok, p}, {1'b1, 15'h2222});
    rd(OFS_PTR);
    chk("ptr_push_pop", d, 32'hE);
    @(posedge mclk);
    ce <= 1'b0;
    @(negedge mclk);
    chk("ce_ready", pready, 1'b0);
    @(posedge mclk);
    ce <= 1'b1;
    final_report();
  end
endmodule
`default_nettype wire

//--- dv/hrs_seq_model.sv
// hrs_seq_model: call and return sequencer facing the stack
`timescale 1ns/1ns
`default_nettype none
module hrs_seq_model
(
  input wire logic mclk,
  output logic push_req,
  output logic [hrs_pkg::PC_W-1:0] push_pc,
  output logic pop_req,
  input wire logic [hrs_pkg::PC_W-1:0] pop_pc,
  input wire logic pop_valid
);
  import hrs_pkg::*;
  initial
  begin
    push_req = 1'b0;
    push_pc = '0;
    pop_req = 1'b0;
  end
  task automatic call_op(input logic [PC_W-1:0] pc);
    @(posedge mclk);
    push_req <= 1'b1;
    push_pc <= pc;
    @(posedge mclk);
    push_req <= 1'b0;
    // stale pc must not look valid after release
    push_pc <= ~pc;
  endtask
  // call, then return in the very next cycle
  task automatic call_ret_op(input logic [PC_W-1:0] pc, output logic [PC_W-1:0] rpc,
    output logic ok);
    @(posedge mclk);
    push_req <= 1'b1;
    push_pc <= pc;
    @(posedge mclk);
    push_req <= 1'b0;
    push_pc <= ~pc;
    pop_req <= 1'b1;
    @(posedge mclk);
    pop_req <= 1'b0;
    @(negedge mclk);
    ok = pop_valid;
    rpc = pop_pc;
  endtask
  // return pops, answer one cycle later
  task automatic ret_op(output logic [PC_W-1:0] pc, output logic ok);
    @(posedge mclk);
    pop_req <= 1'b1;
    @(posedge mclk);
    pop_req <= 1'b0;
    @(negedge mclk);
    ok = pop_valid;
    pc = pop_pc;
  endtask
endmodule
`default_nettype wire

//--- rtl/hrs_mem.sv
// hrs_mem: sixteen-entry storage array of the return stack
`timescale 1ns/1ns
`default_nettype none
module hrs_mem
(
  input wire logic mclk,
  input wire logic ce,
  hrs_mem_if.store port
);
  import hrs_pkg::*;
  // private array, outside program and data address spaces
  logic [PC_W-1:0] entry_reg [HRS_DEPTH];

  // storage keeps no reset: contents are unknown until pushed
  always_ff @(posedge mclk)
  begin
    if (ce && port.we)
    begin
      entry_reg[port.waddr] <= port.wdata;
    end
  end

  assign port.rdata = entry_reg[port.raddr];
endmodule
`default_nettype wire

//--- rtl/hrs_mem_if.sv
// hrs_mem_if: port bundle between the stack control and its storage
`timescale 1ns/1ns
`default_nettype none
interface hrs_mem_if;
  import hrs_pkg::*;
  logic we;
  logic [IDX_W-1:0] waddr;
  logic [PC_W-1:0] wdata;
  logic [IDX_W-1:0] raddr;
  logic [PC_W-1:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

//--- rtl/hrs_pkg.sv
// hrs_pkg: constants shared by the hardware return stack files
package hrs_pkg;
  localparam int HRS_DEPTH = 16;
  localparam int PC_W = 15;
  localparam int PTR_W = 5;
  localparam int IDX_W = 4;
  localparam int LOW_W = 8;
  localparam int HIGH_W = 7;
  localparam int ADDR_W = 8;
  // ---------------------------------------------------------------
  // pointer values
  // ---------------------------------------------------------------
  localparam logic [PTR_W-1:0] PTR_RESET = 5'h1F;
  localparam logic [PTR_W-1:0] PTR_TOP = 5'h0F;
  localparam logic [PTR_W-1:0] PTR_ONE = 5'h01;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_PTR = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TOP_ENTRY_LOW_BYTE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TOP_ENTRY_HIGH_BYTE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CFG = 8'h14;
  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_UNF_BIT = 1;
  localparam int CFG_FRE_BIT = 0;
  localparam logic CFG_FRE_RESET = 1'b1;
  localparam logic [1:0] MASK_RESET = 2'h0;
  localparam logic [1:0] STAT_RESET = 2'h0;
endpackage

//--- rtl/hrs_top.sv
// hrs_top: hardware return stack with apb register access
`timescale 1ns/1ns
`default_nettype none
// Contract
// [R1] sixteen entries of fifteen bits each
// [R2] storage outside program and data space
// [R3] push on call, computed call, interrupt
// [R4] pop on any return kind
// [R5] push and pop leave pc latch alone
// [R6] fault reset off: stack wraps circularly
// [R7] overflow and underflow always set flags
// [R8] fault reset on: reset and set flag
// [R9] software reads writes pointer and top bytes
// [R10] five bit pointer detects overflow underflow
// [R11] pointer addresses entry in use
// [R12] push increments first, pop reads first
// [R13] software careful changing pointer with interrupts
// [R14] flags survive fault reset until cleared
module hrs_top
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [hrs_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic push_req,
  input wire logic [hrs_pkg::PC_W-1:0] push_pc,
  input wire logic pop_req,
  output logic [hrs_pkg::PC_W-1:0] pop_pc,
  output logic pop_valid,
  output logic fault_reset,
  output logic irq
);
  import hrs_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [PTR_W-1:0] ptr_reg;
  logic [PTR_W-1:0] ptr_next;
  logic [PTR_W-1:0] ptr_inc;
  logic [1:0] stat_reg;
  logic [1:0] mask_reg;
  logic cfg_fre_reg;
  logic [31:0] prdata_reg;
  logic [PC_W-1:0] pop_pc_reg;
  logic pop_valid_reg;
  logic fault_reset_reg;

  hrs_mem_if mem_bus ();

  // [R1] sixteen entry storage
  // [R2] storage private to this block
  hrs_mem u_mem (
    .mclk(mclk),
    .ce(ce),
    .port(mem_bus.store)
  );

  // ---------------------------------------------------------------
  // sequencer events
  // ---------------------------------------------------------------
  logic seq_push;
  logic seq_pop;
  logic ovf_evt;
  logic unf_evt;
  logic fault;

  // [R3] push request from call or interrupt vectoring
  assign seq_push = ce & push_req;
  // [R4] pop request from returns; push wins a tie
  assign seq_pop = ce & pop_req & ~push_req;

  // [R10] five bit pointer sees levels past the top and below empty
  assign ovf_evt = seq_push & (ptr_reg >= PTR_TOP) & (ptr_reg != PTR_RESET);
  assign unf_evt = seq_pop & (ptr_reg == PTR_RESET);
  // [R8] fault only when the reset option is on
  assign fault = cfg_fre_reg & (ovf_evt | unf_evt);

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic acc_wr;
  logic setup_rd;
  logic addr_hit;
  logic wr_ptr;
  logic wr_top_entry_low_byte;
  logic wr_top_entry_high_byte;
  logic wr_stat;
  logic wr_mask;
  logic wr_cfg;

  assign acc_wr = ce & psel & penable & pwrite;
  assign setup_rd = ce & psel & ~penable & ~pwrite;
  assign addr_hit = (paddr == OFS_PTR) | (paddr == OFS_TOP_ENTRY_LOW_BYTE) | (paddr == OFS_TOP_ENTRY_HIGH_BYTE) |
                    (paddr == OFS_STAT) | (paddr == OFS_MASK) | (paddr == OFS_CFG);
  assign wr_ptr = acc_wr & (paddr == OFS_PTR);
  assign wr_top_entry_low_byte = acc_wr & (paddr == OFS_TOP_ENTRY_LOW_BYTE);
  assign wr_top_entry_high_byte = acc_wr & (paddr == OFS_TOP_ENTRY_HIGH_BYTE);
  assign wr_stat = acc_wr & (paddr == OFS_STAT);
  assign wr_mask = acc_wr & (paddr == OFS_MASK);
  assign wr_cfg = acc_wr & (paddr == OFS_CFG);

  // zero wait states; ce low stalls the bus with everything else
  assign pready = ce;
  assign pslverr = psel & penable & ~addr_hit;
  assign prdata = prdata_reg;

  // ---------------------------------------------------------------
  // stack pointer
  // ---------------------------------------------------------------
  assign ptr_inc = ptr_reg + PTR_ONE;

  always_comb
  begin
    ptr_next = ptr_reg;
    if (fault)
    begin
      ptr_next = PTR_RESET;
    end
    else if (seq_push)
    begin
      // [R12] increment first, entry written at the new level
      ptr_next = ptr_inc;
    end
    else if (seq_pop)
    begin
      // [R12] value read at the current level, then decrement
      ptr_next = ptr_reg - PTR_ONE;
    end
    else if (wr_ptr)
    begin
      // [R13] a sequencer event in the same cycle wins over software
      ptr_next = pwdata[PTR_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ptr_reg <= PTR_RESET;
    end
    else if (ce)
    begin
      ptr_reg <= ptr_next;
    end
  end

  // ---------------------------------------------------------------
  // storage access
  // ---------------------------------------------------------------
  logic sw_tos_wr;
  logic [PC_W-1:0] tos_merged;

  assign sw_tos_wr = (wr_top_entry_low_byte | wr_top_entry_high_byte) & ~seq_push & ~seq_pop;

  always_comb
  begin
    tos_merged = mem_bus.rdata;
    if (wr_top_entry_low_byte)
    begin
      tos_merged[LOW_W-1:0] = pwdata[LOW_W-1:0];
    end
    if (wr_top_entry_high_byte)
    begin
      tos_merged[PC_W-1:LOW_W] = pwdata[HIGH_W-1:0];
    end
  end

  // [R5] only the pushed pc or a software top byte write is stored; no pc latch is touched here
  // [R6] low four bits index the array, so pushes past sixteen wrap
  assign mem_bus.we = (seq_push & ~fault) | sw_tos_wr;
  assign mem_bus.waddr = seq_push ? ptr_inc[IDX_W-1:0] : ptr_reg[IDX_W-1:0];
  assign mem_bus.wdata = seq_push ? push_pc : tos_merged;
  // [R11] the read side always shows the entry in use
  assign mem_bus.raddr = ptr_reg[IDX_W-1:0];

  // ---------------------------------------------------------------
  // pop answer and fault pulse
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pop_pc_reg <= '0;
      pop_valid_reg <= 1'b0;
    end
    else if (ce)
    begin
      pop_valid_reg <= seq_pop;
      if (seq_pop)
      begin
        pop_pc_reg <= mem_bus.rdata;
      end
    end
  end

  assign pop_pc = pop_pc_reg;
  assign pop_valid = pop_valid_reg;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fault_reset_reg <= 1'b0;
    end
    else if (ce)
    begin
      // [R8] one cycle reset request to the device reset logic
      fault_reset_reg <= fault;
    end
  end

  assign fault_reset = fault_reset_reg;

  // ---------------------------------------------------------------
  // status, mask, configuration
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stat_reg <= STAT_RESET;
    end
    else if (ce)
    begin
      // [R7] events set flags in either mode, set beats clear
      // [R14] only power-on reset or a software one clears them
      stat_reg[STAT_OVF_BIT] <= ovf_evt |
        (stat_reg[STAT_OVF_BIT] & ~(wr_stat & pwdata[STAT_OVF_BIT]));
      stat_reg[STAT_UNF_BIT] <= unf_evt |
        (stat_reg[STAT_UNF_BIT] & ~(wr_stat & pwdata[STAT_UNF_BIT]));
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mask_reg <= MASK_RESET;
      cfg_fre_reg <= CFG_FRE_RESET;
    end
    else if (ce)
    begin
      if (wr_mask)
      begin
        mask_reg <= pwdata[1:0];
      end
      if (wr_cfg)
      begin
        cfg_fre_reg <= pwdata[CFG_FRE_BIT];
      end
    end
  end

  assign irq = |(stat_reg & mask_reg);

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prdata_reg <= '0;
    end
    else if (setup_rd)
    begin
      // [R9] pointer and both top bytes readable
      case (paddr)
        OFS_PTR: prdata_reg <= {27'h0, ptr_reg};
        OFS_TOP_ENTRY_LOW_BYTE: prdata_reg <= {24'h0, mem_bus.rdata[LOW_W-1:0]};
        OFS_TOP_ENTRY_HIGH_BYTE: prdata_reg <= {25'h0, mem_bus.rdata[PC_W-1:LOW_W]};
        OFS_STAT: prdata_reg <= {30'h0, stat_reg};
        OFS_MASK: prdata_reg <= {30'h0, mask_reg};
        OFS_CFG: prdata_reg <= {31'h0, cfg_fre_reg};
        default: prdata_reg <= 32'h0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  property p_push_inc;
    seq_push && !fault |=> ptr_reg == PTR_W'($past(ptr_reg) + PTR_ONE);
  endproperty
  a_push_inc: assert property (p_push_inc) else $error("push did not step pointer up"); // [R12]

  property p_pop_dec;
    seq_pop && !fault |=> ptr_reg == PTR_W'($past(ptr_reg) - PTR_ONE);
  endproperty
  a_pop_dec: assert property (p_pop_dec) else $error("pop did not step pointer down"); // [R12]

  property p_ovf_flag;
    ovf_evt |=> stat_reg[STAT_OVF_BIT];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set"); // [R7]

  property p_unf_flag;
    unf_evt |=> stat_reg[STAT_UNF_BIT];
  endproperty
  a_unf_flag: assert property (p_unf_flag) else $error("underflow flag not set"); // [R7]

  property p_fault;
    fault |=> fault_reset && ptr_reg == PTR_RESET ##1 (!fault_reset || $past(fault) || !$past(ce));
  endproperty
  a_fault: assert property (p_fault) else $error("fault reset wrong"); // [R8]

  property p_circ;
    (ovf_evt || unf_evt) && !cfg_fre_reg |=> !fault_reset;
  endproperty
  a_circ: assert property (p_circ) else $error("fault reset in circular mode"); // [R6]

  property p_keep;
    fault && ovf_evt |=> stat_reg[STAT_OVF_BIT] ##1 stat_reg[STAT_OVF_BIT] || $past(wr_stat);
  endproperty
  a_keep: assert property (p_keep) else $error("flag lost on fault reset"); // [R14]

  property p_round_trip;
    seq_push && !fault ##1 seq_pop && !fault |=> pop_valid && pop_pc == $past(push_pc, 2);
  endproperty
  a_round_trip: assert property (p_round_trip) else $error("pop returned wrong pc"); // [R3]

  property p_tos_view;
    wr_top_entry_low_byte && sw_tos_wr && !wr_ptr ##1 ce |-> mem_bus.rdata[LOW_W-1:0] == $past(pwdata[7:0]);
  endproperty
  a_tos_view: assert property (p_tos_view) else $error("low byte write not visible"); // [R9]

  property p_irq;
    ovf_evt && mask_reg[STAT_OVF_BIT] && !wr_mask |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("masked-in overflow gave no interrupt"); // [R7]

  c_overflow: cover property (ovf_evt && !cfg_fre_reg);
  c_underflow: cover property (unf_evt);
  c_fault: cover property (fault_reset);
  c_round_trip: cover property (seq_push ##1 seq_pop);
endmodule
`default_nettype wire
